// file: src/abf_defs.svh
/*
 * Constants shared by both ends of the command/response framer.
 * Assumes inclusion by bare name from both end modules.
 */
`ifndef ABF_DEFS_SVH
`define ABF_DEFS_SVH

// ----------------------------------------------------------------
// Command layout
// ----------------------------------------------------------------
`define ABF_HDR_LEN      9'h004  // Header bytes before the body
`define ABF_LEN_CASE2    9'h005  // Header plus one expected length
`define ABF_LEN_CASE4X   9'h006  // Header, Lc and Le, data excluded
`define ABF_POS_CLA      9'h000  // Byte positions in the message
`define ABF_POS_INS      9'h001
`define ABF_POS_P1       9'h002
`define ABF_POS_P2       9'h003
`define ABF_POS_B4       9'h004
`define ABF_CNT_SAT      9'h1fe  // Counter ceiling, no wrap

// ----------------------------------------------------------------
// Header and length checks
// ----------------------------------------------------------------
`define ABF_CLA_INVALID  8'hff   // Forbidden class byte
`define ABF_INS_NIB_A    4'h6    // Forbidden instruction nibbles
`define ABF_INS_NIB_B    4'h9
`define ABF_LC_ZERO      8'h00   // Lc may never be zero
`define ABF_LE_ZERO_MAX  9'h100  // Le of zero means 256

// ----------------------------------------------------------------
// Status bytes that may carry data
// ----------------------------------------------------------------
`define ABF_SW1_MORE     8'h61
`define ABF_SW1_WARN_A   8'h62
`define ABF_SW1_WARN_B   8'h63
`define ABF_SW1_APP_NIB  4'h9

// ----------------------------------------------------------------
// Block chaining
// ----------------------------------------------------------------
`define ABF_BLK_MAX      8'hfe   // Bytes per information field

`endif

// file: src/abf_pkg.sv
/*
 * Types shared by both ends of the framer.
 * Assumes nothing of its surroundings.
 */
package abf_pkg;

    // ------------------------------------------------------------
    // Command cases
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ABF_CASE_BAD = 3'h0,  // Matches no layout
        ABF_CASE_1   = 3'h1,  // No data either way
        ABF_CASE_2   = 3'h2,  // Response data only
        ABF_CASE_3   = 3'h3,  // Command data only
        ABF_CASE_4   = 3'h4   // Data both ways
    } abf_case_t;

    // ------------------------------------------------------------
    // State machines
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ABF_D_CMD  = 3'h0,  // Receiving a command
        ABF_D_STAT = 3'h1,  // Waiting for the status
        ABF_D_DATA = 3'h2,  // Passing response data
        ABF_D_SW1  = 3'h3,  // Sending first status byte
        ABF_D_SW2  = 3'h4,  // Sending second status byte
        ABF_D_FIN  = 3'h5   // Waiting for last byte to go
    } abf_card_st_t;

    typedef enum logic {
        ABF_H_SEND = 1'h0,  // Forwarding a command
        ABF_H_WAIT = 1'h1   // Awaiting its response
    } abf_term_st_t;

endpackage

// file: src/abf_link_if.sv
/*
 * Byte link between terminal end and card end.
 * Assumes both ends share one clock; the bench joins them.
 */
`timescale 1ns/1ps

interface abf_link_if;

    // ------------------------------------------------------------
    // Command direction, terminal to card
    // ------------------------------------------------------------
    logic       c_valid;    // Byte offered
    logic       c_ready;    // Byte taken
    logic [7:0] c_data;     // Command byte
    logic       c_blk_end;  // Last byte of a block
    logic       c_last;     // Last byte of the message

    // ------------------------------------------------------------
    // Response direction, card to terminal
    // ------------------------------------------------------------
    logic       r_valid;
    logic       r_ready;
    logic [7:0] r_data;
    logic       r_blk_end;
    logic       r_last;

    modport term (
        output c_valid, c_data, c_blk_end, c_last, r_ready,
        input  c_ready, r_valid, r_data, r_blk_end, r_last
    );

    modport card (
        input  c_valid, c_data, c_blk_end, c_last, r_ready,
        output c_ready, r_valid, r_data, r_blk_end, r_last
    );

endinterface

// file: src/abf_term_end.sv
/*
 * Terminal transport end: forwards commands onto the link in
 * chained blocks and hands the response upward unaltered.
 * Assumes a card end on the link and a user on the same clock.
 */
`timescale 1ns/1ps
`include "abf_defs.svh"

module abf_term_end
    import abf_pkg::*;
#(
    parameter logic [7:0] BLK_MAX = `ABF_BLK_MAX  // Bytes per block
) (
    input  wire logic       clk_sys_in,
    input  wire logic       rst_in,
    input  wire logic       u_valid_in,     // Command byte offered
    input  wire logic [7:0] u_data_in,      // Command byte
    input  wire logic       u_last_in,      // Final command byte
    output logic            u_ready_out,    // Command byte taken
    output logic            rsp_valid_out,  // Response byte ready
    output logic [7:0]      rsp_data_out,   // Response byte
    output logic            rsp_last_out,   // Final response byte
    input  wire logic       rsp_ready_in,   // User takes byte
    output logic            busy_out,       // Exchange in flight
    abf_link_if.term        link
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    abf_term_st_t st_reg, st_next;    // Exchange state
    logic         c_valid_reg;        // Link output stage
    logic [7:0]   c_data_reg;
    logic         c_blk_reg, c_last_reg;
    logic [7:0]   blk_cnt_reg;        // Bytes in current block
    logic         u_ready_reg, r_ready_reg;
    logic         ld, c_valid_next, r_acc;
    logic         hv_reg, sv_reg, sv_next;  // Two-entry buffer
    logic [8:0]   hd_reg, sd_reg, din;
    logic         push, pop;

    assign link.c_valid   = c_valid_reg;
    assign link.c_data    = c_data_reg;
    assign link.c_blk_end = c_blk_reg;
    assign link.c_last    = c_last_reg;
    assign link.r_ready   = r_ready_reg;
    assign u_ready_out    = u_ready_reg;
    assign rsp_valid_out  = hv_reg;
    assign rsp_data_out   = hd_reg[7:0];
    assign rsp_last_out   = hd_reg[8];

    // Handshakes
    assign ld           = u_valid_in & u_ready_reg;
    assign c_valid_next = ld | (c_valid_reg & ~link.c_ready);
    assign r_acc        = link.r_valid & r_ready_reg;
    assign push         = r_acc;
    assign pop          = hv_reg & rsp_ready_in;
    assign din          = {link.r_last, link.r_data};
    assign sv_next      = (push & (pop ? sv_reg : hv_reg))
                        | (~pop & sv_reg);

    // ------------------------------------------------------------
    // Exchange sequencing
    // ------------------------------------------------------------
    // One command, then wait for its whole response
    always_comb begin
        st_next = st_reg;
        unique case (st_reg)
            ABF_H_SEND: if (ld & u_last_in) begin
                st_next = ABF_H_WAIT;
            end
            ABF_H_WAIT: if (r_acc & link.r_last) begin
                st_next = ABF_H_SEND;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            st_reg      <= ABF_H_SEND;
            busy_out    <= 1'b0;
            u_ready_reg <= 1'b0;
            r_ready_reg <= 1'b0;
        end else begin
            st_reg      <= st_next;
            busy_out    <= (st_next == ABF_H_WAIT);
            u_ready_reg <= (st_next == ABF_H_SEND) & ~c_valid_next;
            r_ready_reg <= (st_next == ABF_H_WAIT) & ~sv_next;
        end
    end

    // ------------------------------------------------------------
    // Command output stage with block chaining
    // ------------------------------------------------------------
    // Bytes pass unmodified; blocks split at BLK_MAX
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            c_valid_reg <= 1'b0;
            c_data_reg  <= 8'h00;
            c_blk_reg   <= 1'b0;
            c_last_reg  <= 1'b0;
            blk_cnt_reg <= 8'h00;
        end else begin
            c_valid_reg <= c_valid_next;
            if (ld) begin
                c_data_reg <= u_data_in;
                c_last_reg <= u_last_in;
                c_blk_reg  <= u_last_in
                            | (blk_cnt_reg == BLK_MAX - 8'h01);
                if (u_last_in | (blk_cnt_reg == BLK_MAX - 8'h01)) begin
                    blk_cnt_reg <= 8'h00;
                end else begin
                    blk_cnt_reg <= blk_cnt_reg + 8'h01;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Response buffer towards the user
    // ------------------------------------------------------------
    // Two entries; link stalls when the spare is taken
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            hv_reg <= 1'b0;
            sv_reg <= 1'b0;
            hd_reg <= 9'h000;
            sd_reg <= 9'h000;
        end else begin
            hv_reg <= push | sv_reg | (hv_reg & ~pop);
            sv_reg <= sv_next;
            if (pop & sv_reg) begin
                hd_reg <= sd_reg;
            end else if (push & (pop | ~hv_reg)) begin
                hd_reg <= din;
            end
            if (push & (pop ? sv_reg : hv_reg)) begin
                sd_reg <= din;
            end
        end
    end

endmodule

// file: src/abf_card_end.sv
/*
 * Card end: frames and checks commands from the link, hands the
 * body upward, and frames the response with its status trailer.
 * Assumes a terminal end on the link and a card application on
 * the same clock that supplies status and response data.
 */
`timescale 1ns/1ps
`include "abf_defs.svh"

module abf_card_end
    import abf_pkg::*;
#(
    parameter logic [7:0] BLK_MAX = `ABF_BLK_MAX  // Bytes per block
) (
    input  wire logic       clk_sys_in,
    input  wire logic       rst_in,
    input  wire logic       sm_active_in,  // Secure messaging on
    output logic [7:0]      cla_out,       // Header bytes
    output logic [7:0]      ins_out,
    output logic [7:0]      p1_out,
    output logic [7:0]      p2_out,
    output abf_case_t       case_out,      // Decoded case
    output logic [7:0]      lc_out,        // Command data length
    output logic [8:0]      le_max_out,    // Response data limit
    output logic            cmd_done_out,  // Command complete
    output logic            cmd_err_out,   // Command rejected
    output logic            cd_valid_out,  // Command data byte
    output logic [7:0]      cd_data_out,
    input  wire logic       cd_ready_in,
    input  wire logic       sw_valid_in,   // Status offered
    input  wire logic [7:0] sw1_in,
    input  wire logic [7:0] sw2_in,
    input  wire logic       has_data_in,   // Data will follow
    output logic            sw_ready_out,  // Status taken
    input  wire logic       rd_valid_in,   // Response data byte
    input  wire logic [7:0] rd_data_in,
    input  wire logic       rd_last_in,
    output logic            rd_ready_out,
    abf_link_if.card        link
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Expected length as a byte count
    function automatic logic [8:0] le_len(input logic [7:0] b);
        le_len = (b == 8'h00) ? `ABF_LE_ZERO_MAX : {1'b0, b};
    endfunction

    // Statuses that may carry data
    function automatic logic sw_allows(input logic [7:0] s);
        sw_allows = (s == `ABF_SW1_MORE) | (s == `ABF_SW1_WARN_A)
                  | (s == `ABF_SW1_WARN_B)
                  | (s[7:4] == `ABF_SW1_APP_NIB);
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    abf_card_st_t st_reg, st_next;   // Exchange state
    logic [8:0]   cnt_reg;           // Bytes seen in command
    logic [7:0]   b4_reg;            // Fifth byte, Lc or Le
    logic         c_ready_reg, c_acc, is_data;
    logic [8:0]   len, dec_le;       // Decode results
    logic [7:0]   dec_lc;
    abf_case_t    dec_case;
    logic         dec_err;
    logic [7:0]   sw1_reg, sw2_reg;  // Held status
    logic         allow_reg;         // Data may go out
    logic [8:0]   sent_reg;          // Data bytes sent
    logic         sw_ready_reg, rd_ready_reg, sw_take, rd_take;
    logic         r_valid_reg, r_blk_reg, r_last_reg, out_free;
    logic [7:0]   r_data_reg, blk_cnt_reg, ld_data;
    logic         ld, ld_last, ld_blk, r_valid_next;
    logic         hv_reg, sv_reg, sv_next, push, pop;
    logic [7:0]   hd_reg, sd_reg;

    assign link.c_ready   = c_ready_reg;
    assign link.r_valid   = r_valid_reg;
    assign link.r_data    = r_data_reg;
    assign link.r_blk_end = r_blk_reg;
    assign link.r_last    = r_last_reg;
    assign sw_ready_out   = sw_ready_reg;
    assign rd_ready_out   = rd_ready_reg;
    assign cd_valid_out   = hv_reg;
    assign cd_data_out    = hd_reg;

    // Handshakes
    assign c_acc    = link.c_valid & c_ready_reg;
    assign sw_take  = sw_valid_in & sw_ready_reg;
    assign rd_take  = rd_valid_in & rd_ready_reg;
    assign out_free = ~r_valid_reg | link.r_ready;
    // Bytes after Lc, up to Lc of them, are the data field
    assign is_data  = (cnt_reg > `ABF_POS_B4)
                    & (cnt_reg < `ABF_LEN_CASE2 + {1'b0, b4_reg});
    assign push     = c_acc & is_data;
    assign pop      = hv_reg & cd_ready_in;
    assign sv_next  = (push & (pop ? sv_reg : hv_reg))
                    | (~pop & sv_reg);

    // ------------------------------------------------------------
    // Command decode on the final byte
    // ------------------------------------------------------------
    always_comb begin
        len      = cnt_reg + 9'h001;
        dec_case = ABF_CASE_BAD;
        dec_lc   = 8'h00;
        dec_le   = 9'h000;
        if (len == `ABF_HDR_LEN) begin
            dec_case = ABF_CASE_1;
        end else if (len == `ABF_LEN_CASE2) begin
            dec_case = ABF_CASE_2;
            dec_le   = le_len(link.c_data);
        end else if (len > `ABF_LEN_CASE2 && b4_reg != `ABF_LC_ZERO) begin
            dec_lc = b4_reg;
            if (len == `ABF_LEN_CASE2 + {1'b0, b4_reg}) begin
                dec_case = ABF_CASE_3;
            end else if (len == `ABF_LEN_CASE4X + {1'b0, b4_reg}) begin
                dec_case = ABF_CASE_4;
                dec_le   = le_len(link.c_data);
            end
        end
        dec_err = (dec_case == ABF_CASE_BAD)
                | (cla_out == `ABF_CLA_INVALID)
                | ins_out[0]
                | (ins_out[7:4] == `ABF_INS_NIB_A)
                | (ins_out[7:4] == `ABF_INS_NIB_B)
                | (sm_active_in & ((dec_case == ABF_CASE_1)
                                 | (dec_case == ABF_CASE_2)));
    end

    // ------------------------------------------------------------
    // Command reception
    // ------------------------------------------------------------
    // Header captured in order, then body counted
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_reg      <= 9'h000;
            b4_reg       <= 8'h00;
            cla_out      <= 8'h00;
            ins_out      <= 8'h00;
            p1_out       <= 8'h00;
            p2_out       <= 8'h00;
            case_out     <= ABF_CASE_BAD;
            lc_out       <= 8'h00;
            le_max_out   <= 9'h000;
            cmd_done_out <= 1'b0;
            cmd_err_out  <= 1'b0;
        end else begin
            cmd_done_out <= c_acc & link.c_last;
            cmd_err_out  <= c_acc & link.c_last & dec_err;
            if (c_acc) begin
                if (link.c_last) begin
                    cnt_reg    <= 9'h000;
                    case_out   <= dec_case;
                    lc_out     <= dec_lc;
                    le_max_out <= dec_le;
                end else if (cnt_reg != `ABF_CNT_SAT) begin
                    cnt_reg <= cnt_reg + 9'h001;
                end
                if (cnt_reg == `ABF_POS_CLA) cla_out <= link.c_data;
                if (cnt_reg == `ABF_POS_INS) ins_out <= link.c_data;
                if (cnt_reg == `ABF_POS_P1)  p1_out  <= link.c_data;
                if (cnt_reg == `ABF_POS_P2)  p2_out  <= link.c_data;
                if (cnt_reg == `ABF_POS_B4)  b4_reg  <= link.c_data;
            end
        end
    end

    // ------------------------------------------------------------
    // Command data buffer towards the user
    // ------------------------------------------------------------
    // Two entries; link stalls when the spare is taken
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            hv_reg <= 1'b0;
            sv_reg <= 1'b0;
            hd_reg <= 8'h00;
            sd_reg <= 8'h00;
        end else begin
            hv_reg <= push | sv_reg | (hv_reg & ~pop);
            sv_reg <= sv_next;
            if (pop & sv_reg) begin
                hd_reg <= sd_reg;
            end else if (push & (pop | ~hv_reg)) begin
                hd_reg <= link.c_data;
            end
            if (push & (pop ? sv_reg : hv_reg)) begin
                sd_reg <= link.c_data;
            end
        end
    end

    // ------------------------------------------------------------
    // Exchange sequencing
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        unique case (st_reg)
            ABF_D_CMD:  if (c_acc & link.c_last) st_next = ABF_D_STAT;
            ABF_D_STAT: if (sw_take) begin
                st_next = has_data_in ? ABF_D_DATA : ABF_D_SW1;
            end
            ABF_D_DATA: if (rd_take & rd_last_in) st_next = ABF_D_SW1;
            ABF_D_SW1:  if (out_free) st_next = ABF_D_SW2;
            ABF_D_SW2:  if (out_free) st_next = ABF_D_FIN;
            ABF_D_FIN:  if (out_free) st_next = ABF_D_CMD;
            default:    st_next = ABF_D_CMD;
        endcase
    end

    // Readies follow the next state; one command at a time
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            st_reg       <= ABF_D_CMD;
            c_ready_reg  <= 1'b0;
            sw_ready_reg <= 1'b0;
            rd_ready_reg <= 1'b0;
        end else begin
            st_reg       <= st_next;
            c_ready_reg  <= (st_next == ABF_D_CMD) & ~sv_next;
            sw_ready_reg <= (st_next == ABF_D_STAT);
            rd_ready_reg <= (st_next == ABF_D_DATA) & ~r_valid_next;
        end
    end

    // Status capture and data count
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            sw1_reg   <= 8'h00;
            sw2_reg   <= 8'h00;
            allow_reg <= 1'b0;
            sent_reg  <= 9'h000;
        end else if (sw_take) begin
            sw1_reg   <= sw1_in;
            sw2_reg   <= sw2_in;
            allow_reg <= sw_allows(sw1_in);
            sent_reg  <= 9'h000;
        end else if (ld & (st_reg == ABF_D_DATA)) begin
            sent_reg <= sent_reg + 9'h001;
        end
    end

    // ------------------------------------------------------------
    // Response output stage
    // ------------------------------------------------------------
    // Data is dropped if status forbids it or Le is reached
    always_comb begin
        ld      = 1'b0;
        ld_data = rd_data_in;
        ld_last = 1'b0;
        unique case (st_reg)
            ABF_D_DATA: ld = rd_take & allow_reg
                           & (sent_reg < le_max_out);
            ABF_D_SW1: begin
                ld      = out_free;
                ld_data = sw1_reg;
            end
            ABF_D_SW2: begin
                ld      = out_free;
                ld_data = sw2_reg;
                ld_last = 1'b1;
            end
            default: ;
        endcase
        ld_blk       = ld_last | (blk_cnt_reg == BLK_MAX - 8'h01);
        r_valid_next = ld | (r_valid_reg & ~link.r_ready);
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            r_valid_reg <= 1'b0;
            r_data_reg  <= 8'h00;
            r_blk_reg   <= 1'b0;
            r_last_reg  <= 1'b0;
            blk_cnt_reg <= 8'h00;
        end else begin
            r_valid_reg <= r_valid_next;
            if (ld) begin
                r_data_reg  <= ld_data;
                r_last_reg  <= ld_last;
                r_blk_reg   <= ld_blk;
                blk_cnt_reg <= ld_blk ? 8'h00 : blk_cnt_reg + 8'h01;
            end
        end
    end

endmodule

// file: dv/abf_link_properties.sv
/* Checker of the byte link between the two framer ends.
   Assumes the bench wires it to the link that joins them. */
`timescale 1ns/1ps
module abf_link_properties #(parameter int BLK_MAX = 254) (
    input wire logic       clk_sys_in, rst_in, c_valid, c_ready,
    input wire logic       c_blk_end, c_last, r_valid, r_ready,
    input wire logic       r_blk_end, r_last,
    input wire logic [7:0] c_data, r_data
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    logic [8:0] cnt_reg; // Command bytes so far in this block
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) cnt_reg <= '0;
        else if (c_valid && c_ready)
            cnt_reg <= c_blk_end ? '0 : cnt_reg + 1'b1;
    end
    AST_C_HOLD: assert property (c_valid && !c_ready
        |=> c_valid && $stable(c_data)) else $error("command byte lost");
    AST_R_HOLD: assert property (r_valid && !r_ready
        |=> r_valid && $stable(r_data)) else $error("response byte lost");
    AST_C_END: assert property (c_valid && c_last |-> c_blk_end)
        else $error("message end without block end");
    AST_C_BLK: assert property (c_valid && cnt_reg == BLK_MAX - 1
        |-> c_blk_end) else $error("command block too long");
    AST_R_END: assert property (r_valid && r_last |-> r_blk_end)
        else $error("status end without block end");
    AST_C_GAP: assert property (c_valid && c_ready && c_last
        |=> !c_ready [*3]) else $error("command overlaps response");
    AST_R_SOLO: assert property (r_valid |-> !c_valid)
        else $error("command during response");
    AST_R_DONE: assert property (r_valid && r_ready && r_last
        |=> !r_valid) else $error("bytes after second status byte");
endmodule

// file: dv/apdu_block_framer_checker_test.sv
/* Bench: joins both framer ends and runs command exchanges.
   Assumes design files and the link checker compile first. */
`timescale 1ns/1ps
module apdu_block_framer_checker_test;
    import abf_pkg::*;
    logic       clk_sys_in, rst_in, uv, ul, ur, rv, rl, rr, sm, cd, ce;
    logic       cv, cr, sv, hd, swr, dv, dl, drr, by;
    logic [7:0] ud, rd, s1, s2, dd, lc, ins;
    logic [8:0] lm;
    abf_case_t  cs;
    int         miscompares = 0, cmp_count = 0, ncd;
    abf_link_if lk ();
    abf_term_end #(.BLK_MAX(8'h04)) i_abf_term_end (.clk_sys_in, .rst_in,
        .u_valid_in(uv), .u_data_in(ud), .u_last_in(ul), .u_ready_out(ur),
        .rsp_valid_out(rv), .rsp_data_out(rd), .rsp_last_out(rl),
        .rsp_ready_in(rr), .busy_out(by), .link(lk));
    abf_card_end #(.BLK_MAX(8'h04)) i_abf_card_end (.clk_sys_in, .rst_in,
        .sm_active_in(sm), .cla_out(), .ins_out(ins), .p1_out(), .p2_out(),
        .case_out(cs), .lc_out(lc), .le_max_out(lm), .cmd_done_out(cd),
        .cmd_err_out(ce), .cd_valid_out(cv), .cd_data_out(), .cd_ready_in(cr),
        .sw_valid_in(sv), .sw1_in(s1), .sw2_in(s2), .has_data_in(hd),
        .sw_ready_out(swr), .rd_valid_in(dv), .rd_data_in(dd),
        .rd_last_in(dl), .rd_ready_out(drr), .link(lk));
    abf_link_properties #(.BLK_MAX(4)) i_abf_link_properties (.clk_sys_in,
        .rst_in, .c_valid(lk.c_valid), .c_ready(lk.c_ready),
        .c_blk_end(lk.c_blk_end), .c_last(lk.c_last), .c_data(lk.c_data),
        .r_valid(lk.r_valid), .r_ready(lk.r_ready), .r_data(lk.r_data),
        .r_blk_end(lk.r_blk_end), .r_last(lk.r_last));
    initial begin
        clk_sys_in = 0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end
    always @(posedge clk_sys_in) if (cv === 1'b1) ncd++; // Data bytes out
    task automatic chk(string n, logic [8:0] s, logic [8:0] e);
        cmp_count++;
        if (s !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic results;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Bounded wait: 0 user, 1 status, 2 data ready; 3 command done
    task automatic wt(int s);
        for (int i = 0; i < 400; i++) begin
            if ((s == 0 ? ur : s == 1 ? swr : s == 2 ? drr : cd) === 1) begin
                if (s < 3) @(posedge clk_sys_in) #1;
                return;
            end
            @(posedge clk_sys_in) #1;
        end
        miscompares++;
        results();
    endtask
    // One exchange: send command, answer status, collect response
    task automatic xchg(logic [7:0] c[$], logic m, logic [7:0] a, b, int n,
                        logic [2:0] ec, logic ee, logic [8:0] em);
        logic [7:0] q[$];
        logic       fin;
        int         f;
        fin = 0;
        ncd = 0;
        sm = m;
        f = (a inside {8'h61, 8'h62, 8'h63} || a[7:4] == 4'h9) ?
            (n < em ? n : em) : 0;
        foreach (c[i]) begin
            uv = 1;
            ud = c[i];
            ul = (i == c.size() - 1);
            wt(0);
        end
        uv = 0;
        wt(3);
        chk("case", cs, ec);
        chk("error", ce, ee);
        chk("busy", by, 1);
        chk("ins", ins, c[1]);
        if (!ee) chk("lc", lc, ec > 2 ? c[4] : 0);
        if (!ee) chk("le_max", lm, em);
        fork
            begin
                s1 = a;
                s2 = b;
                hd = n > 0;
                sv = 1;
                wt(1);
                sv = 0;
                for (int k = 0; k < n; k++) begin
                    dv = 1;
                    dd = 8'h40 + k;
                    dl = k == n - 1;
                    wt(2);
                end
                dv = 0;
            end
            for (int j = 0; j < 600 && !fin; j++) begin
                rr = j >= 6; // Stall first to fill the buffer
                if (rv && rr) begin
                    q.push_back(rd);
                    fin = rl;
                end
                @(posedge clk_sys_in) #1;
            end
        join
        chk("last", fin, 1);
        chk("busy", by, 0);
        chk("length", q.size(), f + 2);
        for (int k = 0; k < f; k++) chk("data", q[k], 8'h40 + k);
        chk("sw1", q[f], a);
        chk("sw2", q[f+1], b);
        if (!ee) chk("cmd_data", ncd, ec > 2 ? c[4] : 0);
    endtask
    initial begin
        {uv, ul, rr, sm, sv, hd, dv, dl, ud, s1, s2, dd} = '0;
        cr = 1;
        rst_in = 1;
        repeat (16) @(posedge clk_sys_in);
        #1 rst_in = 0;
        xchg('{8'h00, 8'ha4, 8'h00, 8'h00}, 0, 8'h6a, 8'h82, 2, 1, 0, 0);
        xchg('{8'h00, 8'hb2, 8'h01, 8'h0c, 8'h02}, 0, 8'h90, 8'h00, 3, 2, 0,
             2);
        xchg('{8'h80, 8'hca, 8'h00, 8'h00, 8'h05, 8'h11, 8'h22, 8'h33, 8'h44,
               8'h55}, 0, 8'h62, 8'h83, 1, 3, 0, 0);
        xchg('{8'h00, 8'ha4, 8'h04, 8'h00, 8'h02, 8'h11, 8'h22, 8'h00}, 0,
             8'h61, 8'h02, 3, 4, 0, 9'h100);
        xchg('{8'hff, 8'ha4, 8'h00, 8'h00}, 0, 8'h6d, 8'h00, 0, 1, 1, 0);
        xchg('{8'h00, 8'ha5, 8'h00, 8'h00}, 0, 8'h6d, 8'h00, 0, 1, 1, 0);
        xchg('{8'h00, 8'h6c, 8'h00, 8'h00}, 0, 8'h6d, 8'h00, 0, 1, 1, 0);
        xchg('{8'h00, 8'h92, 8'h00, 8'h00}, 0, 8'h6d, 8'h00, 0, 1, 1, 0);
        xchg('{8'h00, 8'ha4, 8'h00, 8'h00}, 1, 8'h6d, 8'h00, 0, 1, 1, 0);
        xchg('{8'h00, 8'ha4, 8'h00, 8'h00, 8'h01, 8'h3f}, 1, 8'h93, 8'h01, 1,
             3, 0, 0);
        xchg('{8'h00, 8'ha4, 8'h00, 8'h00, 8'h00, 8'h00}, 0, 8'h67, 8'h00, 0,
             0, 1, 0);
        xchg('{8'h00, 8'ha4, 8'h00, 8'h00, 8'h03, 8'h11}, 0, 8'h67, 8'h00, 0,
             0, 1, 0);
        results();
    end
endmodule
